// [pkg/bf_pkg.sv]
// Constants, register map and field layout of the breaker failure timing block.
package bf_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int STEP_MS = 5;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * STEP_MS;
   localparam int TICK_W = 16;
   localparam int DLY_W = 19;
   localparam int RETRIP_DEFAULT_MS = 100;
   localparam int BF_DEFAULT_MS = 200;
   localparam logic [DLY_W-1:0] RETRIP_DLY_RST = DLY_W'(RETRIP_DEFAULT_MS / STEP_MS);
   localparam logic [DLY_W-1:0] BF_DLY_RST = DLY_W'(BF_DEFAULT_MS / STEP_MS);

   // ----------------------------------------------------------------------
   // Current pick-up, magnitudes in units of 0.001 x In
   // ----------------------------------------------------------------------
   localparam int CUR_W = 16;
   localparam logic [CUR_W-1:0] PHASE_THR_RST = 16'h00c8;
   localparam logic [CUR_W-1:0] RES_THR_RST = 16'h04b0;
   localparam logic [6:0] HYST_PCT = 7'h61;
   localparam logic [6:0] PCT_FULL = 7'h64;

   // ----------------------------------------------------------------------
   // Criterion codes
   // ----------------------------------------------------------------------
   localparam logic [3:0] CRIT_CUR = 4'h0;
   localparam logic [3:0] CRIT_DO = 4'h1;
   localparam logic [3:0] CRIT_SIG = 4'h2;
   localparam logic [3:0] CRIT_CUR_AND_DO = 4'h3;
   localparam logic [3:0] CRIT_CUR_OR_DO = 4'h4;
   localparam logic [3:0] CRIT_CUR_AND_SIG = 4'h5;
   localparam logic [3:0] CRIT_CUR_OR_SIG = 4'h6;
   localparam logic [3:0] CRIT_SIG_OR_DO = 4'h7;
   localparam logic [3:0] CRIT_ANY = 4'h9;
   localparam logic [3:0] CRIT_ALL = 4'ha;

   // ----------------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PHASE_THR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RES_THR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_BACKUP_DLY = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_BF_DLY = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;
   localparam int CTRL_CRIT_LSB = 0;
   localparam int CTRL_RETRIP_EN = 4;
   localparam int CTRL_RES_EN = 5;
   localparam logic [5:0] CTRL_RST = 6'h10;
   localparam int EV_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [pkg/delay_if.sv]
// Connection between the timing control and one delay counter.
`timescale 1ns/1ns
`default_nettype none
interface delay_if;
   logic run;
   logic tick;
   logic [bf_pkg::DLY_W-1:0] limit;
   logic done;
   modport ctl (output run, output tick, output limit, input done);
   modport tmr (input run, input tick, input limit, output done);
endinterface
`default_nettype wire

// [rtl/delay_counter.sv]
// Delay counter that runs on step ticks while its start condition holds.
`timescale 1ns/1ns
`default_nettype none
module delay_counter
(
   input wire logic clk,
   input wire logic rst,
   delay_if.tmr dly
);
   logic [bf_pkg::DLY_W-1:0] count_r;
   logic [bf_pkg::DLY_W-1:0] count_nxt;
   logic done_r;
   logic done_nxt;

   assign dly.done = done_r;

   // Any break in the start condition clears the count, so only unbroken time counts.
   always_comb
   begin
      count_nxt = count_r;
      done_nxt = done_r;
      if (!dly.run)
      begin
         count_nxt = '0;
         done_nxt = 1'b0;
      end
      else if (dly.limit == '0)
      begin
         done_nxt = 1'b1;
      end
      else if (dly.tick && !done_r)
      begin
         count_nxt = count_r + 1'b1;
         done_nxt = (count_nxt >= dly.limit);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         done_r <= done_nxt;
      end
   end
endmodule
`default_nettype wire

// [rtl/current_pickup.sv]
// Current threshold comparator with a fixed release hysteresis.
`timescale 1ns/1ns
`default_nettype none
module current_pickup
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [bf_pkg::CUR_W-1:0] magnitude,
   input wire logic [bf_pkg::CUR_W-1:0] threshold,
   output logic picked
);
   logic [bf_pkg::CUR_W+6:0] product;
   logic [bf_pkg::CUR_W-1:0] release_lvl;
   logic picked_r;
   logic picked_nxt;

   assign product = threshold * bf_pkg::HYST_PCT;
   assign release_lvl = bf_pkg::CUR_W'(product / bf_pkg::PCT_FULL);
   assign picked = picked_r;

   // Between the release level and the threshold the previous state holds.
   always_comb
   begin
      picked_nxt = picked_r;
      if (!enable)
      begin
         picked_nxt = 1'b0;
      end
      else if (magnitude > threshold)
      begin
         picked_nxt = 1'b1;
      end
      else if (magnitude < release_lvl)
      begin
         picked_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         picked_r <= 1'b0;
      end
      else
      begin
         picked_r <= picked_nxt;
      end
   end
endmodule
`default_nettype wire

// [rtl/breaker_failure_timing.sv]
// Top of the breaker failure timing block with its AXI4-Lite register slave.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module breaker_failure_timing
#(
   parameter int TICK_CYCLES = bf_pkg::TICK_CYCLES
)
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic [bf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [bf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [bf_pkg::CUR_W-1:0] PHASE_CURRENT,
   input wire logic [bf_pkg::CUR_W-1:0] RESIDUAL_CURRENT,
   input wire logic TRIP_MONITOR,
   input wire logic SIGNAL_IN,
   input wire logic BLOCK_IN,
   output logic START_OUT,
   output logic BLOCKED_OUT,
   output logic RETRIP_OUT,
   output logic BREAKER_FAILURE_OUTPUT,
   output logic IRQ
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic trip_mon;
   logic sig_in;
   logic blk_in;
   logic [bf_pkg::TICK_W-1:0] tick_cnt_r;
   logic [bf_pkg::TICK_W-1:0] tick_cnt_nxt;
   logic tick_r;
   logic tick_nxt;
   logic phase_pick;
   logic res_pick;
   logic cur_pick;
   logic pick;
   logic start_r;
   logic start_nxt;
   logic blocked_r;
   logic blocked_nxt;
   logic retrip_r;
   logic retrip_nxt;
   logic bf_r;
   logic bf_nxt;
   logic [5:0] ctrl_r;
   logic [5:0] ctrl_nxt;
   logic [bf_pkg::CUR_W-1:0] phase_current_threshold_r;
   logic [bf_pkg::CUR_W-1:0] phase_current_threshold_nxt;
   logic [bf_pkg::CUR_W-1:0] residual_current_threshold_r;
   logic [bf_pkg::CUR_W-1:0] residual_current_threshold_nxt;
   logic [bf_pkg::DLY_W-1:0] backup_coil_delay_r;
   logic [bf_pkg::DLY_W-1:0] backup_coil_delay_nxt;
   logic [bf_pkg::DLY_W-1:0] bf_delay_r;
   logic [bf_pkg::DLY_W-1:0] bf_delay_nxt;
   logic [bf_pkg::EV_W-1:0] irq_stat_r;
   logic [bf_pkg::EV_W-1:0] irq_stat_nxt;
   logic [bf_pkg::EV_W-1:0] irq_mask_r;
   logic [bf_pkg::EV_W-1:0] irq_mask_nxt;
   logic [bf_pkg::EV_W-1:0] events;
   logic [bf_pkg::EV_W-1:0] w1c;
   logic irq_r;
   logic irq_nxt;
   logic aw_hold_r;
   logic aw_hold_nxt;
   logic w_hold_r;
   logic w_hold_nxt;
   logic [bf_pkg::ADDR_W-1:0] awaddr_r;
   logic [bf_pkg::ADDR_W-1:0] awaddr_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0] wstrb_r;
   logic [3:0] wstrb_nxt;
   logic awready_r;
   logic awready_nxt;
   logic wready_r;
   logic wready_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic arready_r;
   logic arready_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic retrip_en;

   delay_if rt_dly ();
   delay_if bf_dly ();

   // ----------------------------------------------------------------------
   // Input synchronisers and step tick
   // ----------------------------------------------------------------------
   assign trip_mon = sync2_r[2];
   assign sig_in = sync2_r[1];
   assign blk_in = sync2_r[0];
   assign retrip_en = ctrl_r[bf_pkg::CTRL_RETRIP_EN];

   // One tick per 5 ms step; the delays are counted in these steps.
   always_comb
   begin
      tick_nxt = 1'b0;
      tick_cnt_nxt = tick_cnt_r + 1'b1;
      if (tick_cnt_r == bf_pkg::TICK_W'(TICK_CYCLES - 1))
      begin
         tick_cnt_nxt = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {TRIP_MONITOR, SIGNAL_IN, BLOCK_IN};
         sync2_r <= sync1_r;
         tick_cnt_r <= tick_cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Pick-up, criterion and blocking
   // ----------------------------------------------------------------------
   current_pickup phase_cmp (
      .clk(SYS_CLK),
      .rst(RESET),
      .enable(1'b1),
      .magnitude(PHASE_CURRENT),
      .threshold(phase_current_threshold_r),
      .picked(phase_pick)
   );

   current_pickup res_cmp (
      .clk(SYS_CLK),
      .rst(RESET),
      .enable(ctrl_r[bf_pkg::CTRL_RES_EN]),
      .magnitude(RESIDUAL_CURRENT),
      .threshold(residual_current_threshold_r),
      .picked(res_pick)
   );

   assign cur_pick = phase_pick | res_pick;

   // The pick-up expression both starts and resets the counters in each criterion.
   always_comb
   begin
      case (ctrl_r[bf_pkg::CTRL_CRIT_LSB +: 4])
         bf_pkg::CRIT_CUR: pick = cur_pick;
         bf_pkg::CRIT_DO: pick = trip_mon;
         bf_pkg::CRIT_SIG: pick = sig_in;
         bf_pkg::CRIT_CUR_AND_DO: pick = cur_pick & trip_mon;
         bf_pkg::CRIT_CUR_OR_DO: pick = cur_pick | trip_mon;
         bf_pkg::CRIT_CUR_AND_SIG: pick = cur_pick & sig_in;
         bf_pkg::CRIT_CUR_OR_SIG: pick = cur_pick | sig_in;
         bf_pkg::CRIT_SIG_OR_DO: pick = sig_in | trip_mon;
         bf_pkg::CRIT_ANY: pick = cur_pick | trip_mon | sig_in;
         bf_pkg::CRIT_ALL: pick = cur_pick & trip_mon & sig_in;
         default: pick = 1'b0;
      endcase
   end

   // A block seen at pick-up latches blocked until pick-up drops, so lifting it mid-fault
   // does not restart timing.
   always_comb
   begin
      blocked_nxt = pick & (blocked_r | blk_in);
      start_nxt = pick & ~blk_in & ~blocked_r;
      retrip_nxt = start_nxt & retrip_en & rt_dly.done;
      bf_nxt = start_nxt & bf_dly.done;
   end

   assign rt_dly.run = start_r & retrip_en;
   assign rt_dly.tick = tick_r;
   assign rt_dly.limit = backup_coil_delay_r;
   assign bf_dly.run = start_r;
   assign bf_dly.tick = tick_r;
   assign bf_dly.limit = bf_delay_r;

   delay_counter rt_cnt (
      .clk(SYS_CLK),
      .rst(RESET),
      .dly(rt_dly.tmr)
   );

   delay_counter bf_cnt (
      .clk(SYS_CLK),
      .rst(RESET),
      .dly(bf_dly.tmr)
   );

   // ----------------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------------
   always_comb
   begin
      events = {bf_nxt & ~bf_r, retrip_nxt & ~retrip_r, blocked_nxt & ~blocked_r,
                start_nxt & ~start_r};
      irq_stat_nxt = (irq_stat_r & ~w1c) | events;
      irq_nxt = |(irq_stat_nxt & irq_mask_r);
   end

   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         start_r <= 1'b0;
         blocked_r <= 1'b0;
         retrip_r <= 1'b0;
         bf_r <= 1'b0;
         irq_stat_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         start_r <= start_nxt;
         blocked_r <= blocked_nxt;
         retrip_r <= retrip_nxt;
         bf_r <= bf_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel and settings
   // ----------------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wmask[i*8 +: 8] = {8{wstrb_r[i]}};
      end
   end

   // The delay registers hold plain step counts; software keeps the grading sane.
   always_comb
   begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ctrl_nxt = ctrl_r;
      phase_current_threshold_nxt = phase_current_threshold_r;
      residual_current_threshold_nxt = residual_current_threshold_r;
      backup_coil_delay_nxt = backup_coil_delay_r;
      bf_delay_nxt = bf_delay_r;
      irq_mask_nxt = irq_mask_r;
      w1c = '0;
      wval = '0;
      if (S_AXI_AWVALID && awready_r)
      begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_r)
      begin
         w_hold_nxt = 1'b1;
         wdata_nxt = S_AXI_WDATA;
         wstrb_nxt = S_AXI_WSTRB;
      end
      if (bvalid_r && S_AXI_BREADY)
      begin
         bvalid_nxt = 1'b0;
      end
      else if (aw_hold_r && w_hold_r && !bvalid_r)
      begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = bf_pkg::RESP_OKAY;
         wval = wdata_r & wmask;
         if (awaddr_r == bf_pkg::OFS_CTRL)
         begin
            ctrl_nxt = 6'((ctrl_r & ~wmask[5:0]) | wval[5:0]);
         end
         else if (awaddr_r == bf_pkg::OFS_PHASE_THR)
         begin
            phase_current_threshold_nxt = (phase_current_threshold_r & ~wmask[15:0]) | wval[15:0];
         end
         else if (awaddr_r == bf_pkg::OFS_RES_THR)
         begin
            residual_current_threshold_nxt = (residual_current_threshold_r & ~wmask[15:0])
               | wval[15:0];
         end
         else if (awaddr_r == bf_pkg::OFS_BACKUP_DLY)
         begin
            backup_coil_delay_nxt = (backup_coil_delay_r & ~wmask[18:0]) | wval[18:0];
         end
         else if (awaddr_r == bf_pkg::OFS_BF_DLY)
         begin
            bf_delay_nxt = (bf_delay_r & ~wmask[18:0]) | wval[18:0];
         end
         else if (awaddr_r == bf_pkg::OFS_IRQ_STAT)
         begin
            w1c = wval[bf_pkg::EV_W-1:0];
         end
         else if (awaddr_r == bf_pkg::OFS_IRQ_MASK)
         begin
            irq_mask_nxt = (irq_mask_r & ~wmask[3:0]) | wval[3:0];
         end
         else if (awaddr_r != bf_pkg::OFS_STATUS)
         begin
            bresp_nxt = bf_pkg::RESP_SLVERR;
         end
      end
      awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
      wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
   end

   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= bf_pkg::RESP_OKAY;
         ctrl_r <= bf_pkg::CTRL_RST;
         phase_current_threshold_r <= bf_pkg::PHASE_THR_RST;
         residual_current_threshold_r <= bf_pkg::RES_THR_RST;
         backup_coil_delay_r <= bf_pkg::RETRIP_DLY_RST;
         bf_delay_r <= bf_pkg::BF_DLY_RST;
         irq_mask_r <= '0;
      end
      else
      begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ctrl_r <= ctrl_nxt;
         phase_current_threshold_r <= phase_current_threshold_nxt;
         residual_current_threshold_r <= residual_current_threshold_nxt;
         backup_coil_delay_r <= backup_coil_delay_nxt;
         bf_delay_r <= bf_delay_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && S_AXI_RREADY)
      begin
         rvalid_nxt = 1'b0;
      end
      else if (S_AXI_ARVALID && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = bf_pkg::RESP_OKAY;
         rdata_nxt = 32'h0;
         if (S_AXI_ARADDR == bf_pkg::OFS_CTRL)
         begin
            rdata_nxt[5:0] = ctrl_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_PHASE_THR)
         begin
            rdata_nxt[15:0] = phase_current_threshold_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_RES_THR)
         begin
            rdata_nxt[15:0] = residual_current_threshold_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_BACKUP_DLY)
         begin
            rdata_nxt[18:0] = backup_coil_delay_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_BF_DLY)
         begin
            rdata_nxt[18:0] = bf_delay_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_STATUS)
         begin
            rdata_nxt[7:0] = {trip_mon, sig_in, cur_pick, pick, bf_r, retrip_r, blocked_r,
                              start_r};
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_IRQ_STAT)
         begin
            rdata_nxt[3:0] = irq_stat_r;
         end
         else if (S_AXI_ARADDR == bf_pkg::OFS_IRQ_MASK)
         begin
            rdata_nxt[3:0] = irq_mask_r;
         end
         else
         begin
            rresp_nxt = bf_pkg::RESP_SLVERR;
         end
      end
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= bf_pkg::RESP_OKAY;
      end
      else
      begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign START_OUT = start_r;
   assign BLOCKED_OUT = blocked_r;
   assign RETRIP_OUT = retrip_r;
   assign BREAKER_FAILURE_OUTPUT = bf_r;
   assign IRQ = irq_r;
endmodule
`default_nettype wire

// [verif/bf_monitor.sv]
// Concurrent checks on the ports of the breaker failure timing block.
`timescale 1ns/1ns
`default_nettype none
module bf_monitor
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic START_OUT,
   input wire logic BLOCKED_OUT,
   input wire logic RETRIP_OUT,
   input wire logic BREAKER_FAILURE_OUTPUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   a_retrip_in_start: assert property (RETRIP_OUT |-> START_OUT)
      else $error("repeat trip without start");
   a_bf_in_start: assert property (BREAKER_FAILURE_OUTPUT |-> START_OUT)
      else $error("breaker failure without start");
   a_start_not_blocked: assert property (!(START_OUT && BLOCKED_OUT))
      else $error("start and blocked together");
   a_retrip_after_start: assert property ($rose(RETRIP_OUT) |-> $past(START_OUT))
      else $error("repeat trip ahead of start");
   a_bf_after_start: assert property ($rose(BREAKER_FAILURE_OUTPUT) |-> $past(START_OUT))
      else $error("breaker failure ahead of start");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_ar_closed: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address open during answer");
   a_aw_closed: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
      else $error("write address open during answer");
endmodule
bind breaker_failure_timing bf_monitor bf_monitor_inst (.SYS_CLK, .RESET, .S_AXI_AWREADY,
   .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .START_OUT, .BLOCKED_OUT,
   .RETRIP_OUT, .BREAKER_FAILURE_OUTPUT);
`default_nettype wire

// [verif/breaker_model.sv]
// Primary breaker trip contact seen by the monitoring input.
`timescale 1ns/1ns
`default_nettype none
module breaker_model
(
   input wire logic clk,
   input wire logic trip_cmd,
   output logic trip_contact
);
   // The contact closes one clock after the command, as a relay would lag.
   always_ff @(posedge clk)
      trip_contact <= trip_cmd;
endmodule
`default_nettype wire

// [verif/breaker_failure_timing_tb_top.sv]
// Self-checking testbench of the breaker failure timing block.
`timescale 1ns/1ns
`default_nettype none
module breaker_failure_timing_tb_top;
   logic SYS_CLK, RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
   logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, TRIP_MONITOR, SIGNAL_IN, BLOCK_IN, START_OUT, BLOCKED_OUT;
   logic RETRIP_OUT, BREAKER_FAILURE_OUTPUT, IRQ, trip_cmd;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, seed, rv;
   logic [15:0] PHASE_CURRENT, RESIDUAL_CURRENT;
   logic [3:0] S_AXI_WSTRB;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
   int errors, n_tests, tr, n, i, c;
   breaker_failure_timing #(.TICK_CYCLES(10)) breaker_failure_timing_inst (.SYS_CLK, .RESET,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
      .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
      .S_AXI_RVALID, .S_AXI_RREADY, .PHASE_CURRENT, .RESIDUAL_CURRENT, .TRIP_MONITOR,
      .SIGNAL_IN, .BLOCK_IN, .START_OUT, .BLOCKED_OUT, .RETRIP_OUT, .BREAKER_FAILURE_OUTPUT,
      .IRQ);
   breaker_model breaker_model_inst (.clk(SYS_CLK), .trip_cmd(trip_cmd),
      .trip_contact(TRIP_MONITOR));
   initial
   begin
      SYS_CLK = 1'b0;
      forever #50 SYS_CLK = ~SYS_CLK;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected {start, blocked, repeat trip, failure} once every delay has run out.
   function automatic logic [3:0] model(input int c, input logic [7:0] b);
      logic pu, cu;
      cu = b[1] | (b[6] & b[7]);
      case (c)
         0: pu = cu;
         1: pu = b[2];
         2: pu = b[3];
         3: pu = cu & b[2];
         4: pu = cu | b[2];
         5: pu = cu & b[3];
         6: pu = cu | b[3];
         7: pu = b[3] | b[2];
         9: pu = cu | b[2] | b[3];
         10: pu = cu & b[2] & b[3];
         default: pu = 1'b0;
      endcase
      return !pu ? 4'h0 : (b[4] & b[5]) ? 4'h4 : {2'b10, b[0], 1'b1};
   endfunction
   task give_verdict(input int extra);
      errors += extra;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask
   task chk_pins(input logic [3:0] exp);
      chk({START_OUT, BLOCKED_OUT, RETRIP_OUT, BREAKER_FAILURE_OUTPUT}, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
      for (n = 0; n < 50 && !(S_AXI_BREADY && S_AXI_BVALID); n++)
      begin
         @(posedge SYS_CLK);
         if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end
      rr = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      if (n == 50) give_verdict(1);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge SYS_CLK);
      S_AXI_ARADDR <= a;
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
      for (n = 0; n < 50 && !(S_AXI_RREADY && S_AXI_RVALID); n++)
      begin
         @(posedge SYS_CLK);
         if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end
      rv = S_AXI_RDATA;
      rr = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      if (n == 50) give_verdict(1);
   endtask
   initial
   begin
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
      {PHASE_CURRENT, RESIDUAL_CURRENT, trip_cmd, SIGNAL_IN, BLOCK_IN} = 35'h0;
      S_AXI_WSTRB = 4'hf;
      RESET = 1'b1;
      errors = 0;
      n_tests = 0;
      seed = 32'h9e1ea43a;
      repeat (12) @(posedge SYS_CLK);
      RESET <= 1'b0;
      rd(8'h00);
      chk(rv, 32'h10);
      rd(8'h0c);
      chk(rv, 32'd20);
      rd(8'h10);
      chk(rv, 32'd40);
      rd(8'h20);
      chk(rr, 32'h2);
      wr(8'h24, 32'h1);
      chk(rr, 32'h2);
      $display("test reset values done");
      wr(8'h1c, 32'h8);
      chk(rr, 32'h0);
      wr(8'h0c, 32'h2);
      wr(8'h10, 32'h4);
      PHASE_CURRENT <= 16'h0100;
      for (i = 0; i < 9 && !START_OUT; i++) @(posedge SYS_CLK);
      if (i == 9) give_verdict(1);
      tr = 0;
      for (i = 0; i < 99 && !BREAKER_FAILURE_OUTPUT; i++)
      begin
         @(posedge SYS_CLK);
         if (RETRIP_OUT && tr == 0) tr = i;
      end
      if (i == 99) give_verdict(1);
      chk(tr > 9 && tr < 25, 1);
      chk(i > 30 && i < 46, 1);
      chk(i - 1 - tr, 20);
      chk(IRQ, 1);
      rd(8'h18);
      chk(rv, 32'h0d);
      wr(8'h18, 32'hf);
      @(posedge SYS_CLK);
      chk(IRQ, 0);
      $display("test delays and interrupt done");
      // A level exactly at the 97 percent floor must still hold the pick-up.
      PHASE_CURRENT <= 16'h00c2;
      repeat (9) @(posedge SYS_CLK);
      chk_pins(4'hb);
      PHASE_CURRENT <= 16'h00c1;
      repeat (5) @(posedge SYS_CLK);
      chk_pins(4'h0);
      $display("test hysteresis done");
      for (i = 0; i < 40; i++)
      begin
         seed = lfsr(seed);
         c = seed[15:12] % 11;
         wr(8'h00, {26'h0, seed[9], seed[3], 4'(c)});
         PHASE_CURRENT <= seed[4] ? 16'h00c9 + seed[23:16] : 16'(seed[23:16] % 8'hc1);
         RESIDUAL_CURRENT <= seed[10] ? 16'h04b1 + seed[31:24] : 16'(seed[31:24]);
         trip_cmd <= seed[5];
         SIGNAL_IN <= seed[6];
         BLOCK_IN <= seed[7] & seed[8];
         repeat (70) @(posedge SYS_CLK);
         chk_pins(model(c, seed[10:3]));
         {PHASE_CURRENT, RESIDUAL_CURRENT, trip_cmd, SIGNAL_IN, BLOCK_IN} <= 35'h0;
         repeat (9) @(posedge SYS_CLK);
         chk_pins(4'h0);
      end
      $display("test criteria done");
      give_verdict(0);
   end
endmodule
`default_nettype wire
